// ### src/psr_pkg.sv
package psr_pkg;
    localparam logic [8:0] ADDR_BUCK1_ALT = 9'h0B5;
    localparam logic [8:0] ADDR_BUCK4_ALT = 9'h0B6;
    localparam logic [8:0] ADDR_BUCK3_ALT = 9'h0B8;
    localparam logic [8:0] ADDR_LIN1_ALT = 9'h0BA;
    localparam logic [8:0] ADDR_LIN2_ALT = 9'h0BB;
    localparam logic [8:0] ADDR_LIN3_ALT = 9'h0BC;
    localparam logic [8:0] ADDR_LIN4_ALT = 9'h0BD;
    localparam logic [8:0] ADDR_BACKUP_CHG = 9'h0C5;
    localparam logic [8:0] ADDR_TARGET_ADDR = 9'h105;
    localparam logic [8:0] ADDR_PIN_BUS_CFG = 9'h106;
    localparam logic [8:0] ADDR_FAULT_CFG = 9'h107;
    localparam logic [8:0] ADDR_CLOCK_CFG = 9'h108;
    localparam int SLEEP_BIT = 7;
    localparam int HSM_BIT = 6;
    localparam int FMP_BIT = 5;
    localparam int IRQ_POL_BIT = 3;
    localparam int ODRAIN_BIT = 2;
    localparam int B3_INV_BIT = 6;
    localparam int B4_INV_BIT = 4;
    localparam int B1_INV_BIT = 3;
    localparam int DISCHG_BIT = 2;
    localparam logic [7:0] PIN_CFG_WMASK = 8'h7F;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [11:0] BUCK1_BASE_MV = 12'h12C;
    localparam logic [11:0] BUCK4_BASE_MV = 12'h212;
    localparam logic [11:0] BUCK3_BASE_MV = 12'h320;
    localparam logic [11:0] LIN_BASE_MV = 12'h384;
    localparam logic [5:0] LIN_MIN_CODE = 6'h02;
    localparam logic [5:0] LIN_MAX_CODE = 6'h38;
    localparam logic [11:0] HYST_BASE_MV = 12'h064;
    localparam logic [11:0] FAULT_BASE_MV = 12'h9C4;
    localparam logic [11:0] STEP_50_MV = 12'h032;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    typedef enum logic [1:0] {SEL_SLEEP_BITS, SEL_PFM, SEL_PWM, SEL_AUTO} psr_bucksel_t;
    typedef enum {ST_IDLE, ST_ADDR, ST_ACKA, ST_PTR, ST_ACKP, ST_WR, ST_ACKW, ST_RD, ST_ACKR}
        psr_state_t;
endpackage

// ### src/psr_setting_bank.sv
`timescale 1ns/1ps
`default_nettype none
module psr_setting_bank
    import psr_pkg::*;
#(
    // Arbitrary default for the upper target address bits.
    parameter logic [3:0] BASE_ADDR_DEFAULT = 4'h6
)
(
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // Two-wire serial bus, open drain.
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // Part status.
    input wire logic UNMARKED_PART,
    input wire logic APP_CONFIG_FUSE_LOCK,
    // Buck controls, index 0 buck1, 1 buck3, 2 buck4.
    input wire logic [5:0] BUCK_OPERATING_SELECT,
    input wire logic [2:0] BUCK_ALT_ACTIVE,
    input wire logic [2:0] BUCK_PRIMARY_SLEEP,
    output logic [2:0] BUCK_PFM,
    output logic [2:0] BUCK_AUTO,
    output logic [11:0] BUCK1_ALT_MV,
    output logic [11:0] BUCK3_ALT_MV,
    output logic [11:0] BUCK4_ALT_MV,
    // Linear regulators.
    input wire logic [3:0] LINEAR_ALT_ACTIVE,
    output logic [3:0] LINEAR_ALT_LOW_POWER,
    output logic [47:0] LINEAR_ALT_MV,
    // Backup cell charger.
    output logic [12:0] BACKUP_CHARGE_UA,
    output logic [11:0] BACKUP_CHARGE_TERM_MV,
    // Interface and pin configuration.
    output logic [6:0] TARGET_ADDRESS,
    output logic BUS_HIGH_SPEED_LOCK,
    output logic BUS_FAST_PLUS_SELECT,
    input wire logic IRQ_REQUEST,
    output logic INTERRUPT_REQUEST_PIN_OUT,
    output logic INTERRUPT_REQUEST_PIN_OE,
    input wire logic RESET_REQUEST,
    output logic SYSTEM_RESET_PIN_OUT,
    output logic SYSTEM_RESET_PIN_OE,
    // Supply fault comparator and buck clocks.
    output logic [11:0] SUPPLY_FAULT_HYST_MV,
    output logic [11:0] SUPPLY_FAULT_THRESH_MV,
    output logic [2:0] BUCK_CLOCK_INVERT,
    output logic BUCK_RAIL_DISCHARGE
);
    function automatic logic [11:0] lin_mv(input logic [5:0] code);
        logic [5:0] c;
        c = code;
        if (code < LIN_MIN_CODE)
            c = LIN_MIN_CODE;
        if (code > LIN_MAX_CODE)
            c = LIN_MAX_CODE;
        lin_mv = LIN_BASE_MV + 12'(({6'h00, c} - 12'(LIN_MIN_CODE)) * STEP_50_MV);
    endfunction

    function automatic logic buck_pfm(input logic [1:0] sel, input logic alt,
                                      input logic alt_bit, input logic pri_bit);
        unique case (psr_bucksel_t'(sel))
            SEL_SLEEP_BITS: buck_pfm = alt ? alt_bit : pri_bit;
            SEL_PFM: buck_pfm = 1'b1;
            SEL_PWM: buck_pfm = 1'b0;
            SEL_AUTO: buck_pfm = 1'b0;
        endcase
    endfunction

    // Pin synchronisers; a level is accepted once stages two and three agree.
    logic [2:0] scl_s_q, sda_s_q;
    logic scl_f_q, sda_f_q, scl_p_q, sda_p_q;
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_s_q <= {scl_s_q[1:0], SCL_IN};
            sda_s_q <= {sda_s_q[1:0], SDA_IN};
            if (scl_s_q[1] == scl_s_q[2])
                scl_f_q <= scl_s_q[2];
            if (sda_s_q[1] == sda_s_q[2])
                sda_f_q <= sda_s_q[2];
            scl_p_q <= scl_f_q;
            sda_p_q <= sda_f_q;
        end
    end

    wire scl_rise = scl_f_q & ~scl_p_q;
    wire scl_fall = ~scl_f_q & scl_p_q;
    wire bus_start = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
    wire bus_stop = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

    // Setting registers.
    logic [7:0] buck1_alt_voltage_q, buck4_alt_voltage_q, buck3_alt_voltage_q;
    logic [7:0] linear1_alt_voltage_q, linear2_alt_voltage_q;
    logic [7:0] linear3_alt_voltage_q, linear4_alt_voltage_q;
    logic [7:0] backup_charger_control_q;
    logic [3:0] target_address_high_q;
    logic [7:0] pin_and_bus_config_q, supply_fault_config_q, buck_clock_config_q;

    // Serial target engine.
    psr_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, ptr_q;
    logic page_q, nack_q, sda_oe_q;
    logic wr_stb_q;
    logic [8:0] wr_addr_q;
    logic [7:0] wr_data_q;

    // The second target address reaches the upper register page.
    wire addr_hit = (sh_q[7:4] == target_address_high_q) && (sh_q[3:2] == 2'b00);
    wire byte_done = (cnt_q == BYTE_BITS);
    wire [8:0] rd_addr = {page_q, ptr_q};
    logic [7:0] rd_data;
    always_comb
    begin
        unique case (rd_addr)
            ADDR_BUCK1_ALT: rd_data = buck1_alt_voltage_q;
            ADDR_BUCK4_ALT: rd_data = buck4_alt_voltage_q;
            ADDR_BUCK3_ALT: rd_data = buck3_alt_voltage_q;
            ADDR_LIN1_ALT: rd_data = linear1_alt_voltage_q;
            ADDR_LIN2_ALT: rd_data = linear2_alt_voltage_q;
            ADDR_LIN3_ALT: rd_data = linear3_alt_voltage_q;
            ADDR_LIN4_ALT: rd_data = linear4_alt_voltage_q;
            ADDR_BACKUP_CHG: rd_data = backup_charger_control_q;
            ADDR_TARGET_ADDR: rd_data = {target_address_high_q, 4'h0};
            ADDR_PIN_BUS_CFG: rd_data = pin_and_bus_config_q;
            ADDR_FAULT_CFG: rd_data = supply_fault_config_q;
            ADDR_CLOCK_CFG: rd_data = buck_clock_config_q;
            default: rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        wr_stb_q <= 1'b0;
        if (SYS_RST)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            page_q <= 1'b0;
            nack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            wr_addr_q <= 9'h000;
            wr_data_q <= 8'h00;
        end
        else if (bus_stop)
        begin
            state_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end
        else if (bus_start)
        begin
            state_q <= ST_ADDR;
            cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end
        else if (scl_rise)
        begin
            if (state_q == ST_ADDR || state_q == ST_PTR || state_q == ST_WR)
            begin
                sh_q <= {sh_q[6:0], sda_f_q};
                cnt_q <= cnt_q + 4'h1;
            end
            if (state_q == ST_ACKR)
                nack_q <= sda_f_q;
        end
        else if (scl_fall)
        begin
            unique case (state_q)
                ST_IDLE:
                    sda_oe_q <= 1'b0;
                ST_ADDR:
                    if (byte_done)
                    begin
                        if (addr_hit)
                        begin
                            page_q <= sh_q[1];
                            sh_q[0] <= sh_q[0];
                            sda_oe_q <= 1'b1;
                            state_q <= ST_ACKA;
                        end
                        else
                            state_q <= ST_IDLE;
                    end
                ST_ACKA, ST_ACKR:
                    if ((state_q == ST_ACKA && sh_q[0]) || (state_q == ST_ACKR && !nack_q))
                    begin
                        sh_q <= {rd_data[6:0], 1'b0};
                        sda_oe_q <= ~rd_data[7];
                        cnt_q <= 4'h1;
                        state_q <= ST_RD;
                    end
                    else
                    begin
                        sda_oe_q <= 1'b0;
                        cnt_q <= 4'h0;
                        state_q <= (state_q == ST_ACKA) ? ST_PTR : ST_IDLE;
                    end
                ST_PTR:
                    if (byte_done)
                    begin
                        ptr_q <= sh_q;
                        sda_oe_q <= 1'b1;
                        state_q <= ST_ACKP;
                    end
                ST_ACKP, ST_ACKW:
                begin
                    sda_oe_q <= 1'b0;
                    cnt_q <= 4'h0;
                    state_q <= ST_WR;
                end
                ST_WR:
                    if (byte_done)
                    begin
                        wr_stb_q <= 1'b1;
                        wr_addr_q <= rd_addr;
                        wr_data_q <= sh_q;
                        ptr_q <= ptr_q + 8'h01;
                        sda_oe_q <= 1'b1;
                        state_q <= ST_ACKW;
                    end
                ST_RD:
                    if (byte_done)
                    begin
                        sda_oe_q <= 1'b0;
                        ptr_q <= ptr_q + 8'h01;
                        state_q <= ST_ACKR;
                    end
                    else
                    begin
                        sda_oe_q <= ~sh_q[7];
                        sh_q <= {sh_q[6:0], 1'b0};
                        cnt_q <= cnt_q + 4'h1;
                    end
            endcase
        end
    end

    // Register writes; the address register is frozen once the part is fused.
    wire addr_wr_ok = UNMARKED_PART & ~APP_CONFIG_FUSE_LOCK;
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            buck1_alt_voltage_q <= REG_RESET;
            buck4_alt_voltage_q <= REG_RESET;
            buck3_alt_voltage_q <= REG_RESET;
            linear1_alt_voltage_q <= REG_RESET;
            linear2_alt_voltage_q <= REG_RESET;
            linear3_alt_voltage_q <= REG_RESET;
            linear4_alt_voltage_q <= REG_RESET;
            backup_charger_control_q <= REG_RESET;
            target_address_high_q <= BASE_ADDR_DEFAULT;
            pin_and_bus_config_q <= REG_RESET;
            supply_fault_config_q <= REG_RESET;
            buck_clock_config_q <= REG_RESET;
        end
        else if (wr_stb_q)
        begin
            unique case (wr_addr_q)
                ADDR_BUCK1_ALT: buck1_alt_voltage_q <= wr_data_q;
                ADDR_BUCK4_ALT: buck4_alt_voltage_q <= wr_data_q;
                ADDR_BUCK3_ALT: buck3_alt_voltage_q <= wr_data_q;
                ADDR_LIN1_ALT: linear1_alt_voltage_q <= wr_data_q;
                ADDR_LIN2_ALT: linear2_alt_voltage_q <= wr_data_q;
                ADDR_LIN3_ALT: linear3_alt_voltage_q <= wr_data_q;
                ADDR_LIN4_ALT: linear4_alt_voltage_q <= wr_data_q;
                ADDR_BACKUP_CHG: backup_charger_control_q <= wr_data_q;
                ADDR_TARGET_ADDR:
                    if (addr_wr_ok)
                        target_address_high_q <= wr_data_q[7:4];
                ADDR_PIN_BUS_CFG: pin_and_bus_config_q <= wr_data_q & PIN_CFG_WMASK;
                ADDR_FAULT_CFG: supply_fault_config_q <= wr_data_q;
                ADDR_CLOCK_CFG: buck_clock_config_q <= wr_data_q;
                default: ;
            endcase
        end
    end

    // Decoded settings.
    wire [2:0] alt_sleep = {buck4_alt_voltage_q[SLEEP_BIT], buck3_alt_voltage_q[SLEEP_BIT],
                            buck1_alt_voltage_q[SLEEP_BIT]};
    logic [2:0] pfm_d, auto_d;
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            pfm_d[i] = buck_pfm(BUCK_OPERATING_SELECT[2*i +: 2], BUCK_ALT_ACTIVE[i],
                                alt_sleep[i], BUCK_PRIMARY_SLEEP[i]);
            auto_d[i] = (BUCK_OPERATING_SELECT[2*i +: 2] == 2'(SEL_AUTO));
        end
    end

    wire [3:0] lin_lp = {linear4_alt_voltage_q[SLEEP_BIT], linear3_alt_voltage_q[SLEEP_BIT],
                         linear2_alt_voltage_q[SLEEP_BIT], linear1_alt_voltage_q[SLEEP_BIT]};
    wire [47:0] lin_mv_d = {lin_mv(linear4_alt_voltage_q[5:0]), lin_mv(linear3_alt_voltage_q[5:0]),
                            lin_mv(linear2_alt_voltage_q[5:0]),
                            lin_mv(linear1_alt_voltage_q[5:0])};

    wire [3:0] iset = backup_charger_control_q[7:4];
    wire [3:0] vset = backup_charger_control_q[3:0];
    // Code 1110 is not a listed setting and is treated as disabled.
    wire [12:0] ua_d = (iset == 4'hF) ? 13'h1770 :
                       (iset == 4'hE) ? 13'h0000 :
                       (iset >= 4'hA) ? 13'(({9'h000, iset} - 13'h0009) * 13'h03E8) :
                       13'({9'h000, iset} * 13'h0064);
    logic [11:0] term_d;
    always_comb
    begin
        unique case (vset)
            4'h0: term_d = 12'h000;
            4'h1: term_d = 12'h44C;
            4'h2: term_d = 12'h4B0;
            4'h3: term_d = 12'h578;
            4'h4: term_d = 12'h640;
            4'h5: term_d = 12'h708;
            4'h6: term_d = 12'h7D0;
            4'h7: term_d = 12'h898;
            4'h8: term_d = 12'h960;
            4'h9: term_d = 12'h9C4;
            4'hA: term_d = 12'hA28;
            4'hB: term_d = 12'hA8C;
            4'hC: term_d = 12'hAF0;
            4'hD: term_d = 12'hB54;
            4'hF: term_d = 12'hC1C;
            default: term_d = 12'h000;
        endcase
    end

    // Open drain can only pull low, so an active-high request is signalled by release.
    wire irq_level = IRQ_REQUEST ~^ pin_and_bus_config_q[IRQ_POL_BIT];
    wire odrain = pin_and_bus_config_q[ODRAIN_BIT];
    wire rst_level = ~RESET_REQUEST;

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            SDA_OUT <= 1'b0;
            SDA_OE <= 1'b0;
            BUCK_PFM <= 3'h0;
            BUCK_AUTO <= 3'h0;
            BUCK1_ALT_MV <= BUCK1_BASE_MV;
            BUCK3_ALT_MV <= BUCK3_BASE_MV;
            BUCK4_ALT_MV <= BUCK4_BASE_MV;
            LINEAR_ALT_LOW_POWER <= 4'h0;
            LINEAR_ALT_MV <= {4{LIN_BASE_MV}};
            BACKUP_CHARGE_UA <= 13'h0000;
            BACKUP_CHARGE_TERM_MV <= 12'h000;
            TARGET_ADDRESS <= {BASE_ADDR_DEFAULT, 3'h0};
            BUS_HIGH_SPEED_LOCK <= 1'b0;
            BUS_FAST_PLUS_SELECT <= 1'b0;
            INTERRUPT_REQUEST_PIN_OUT <= 1'b1;
            INTERRUPT_REQUEST_PIN_OE <= 1'b1;
            SYSTEM_RESET_PIN_OUT <= 1'b1;
            SYSTEM_RESET_PIN_OE <= 1'b1;
            SUPPLY_FAULT_HYST_MV <= HYST_BASE_MV;
            SUPPLY_FAULT_THRESH_MV <= FAULT_BASE_MV;
            BUCK_CLOCK_INVERT <= 3'h0;
            BUCK_RAIL_DISCHARGE <= 1'b0;
        end
        else
        begin
            SDA_OUT <= 1'b0;
            SDA_OE <= sda_oe_q;
            BUCK_PFM <= pfm_d;
            BUCK_AUTO <= auto_d;
            BUCK1_ALT_MV <= BUCK1_BASE_MV + 12'(buck1_alt_voltage_q[6:0] * 8'd10);
            BUCK3_ALT_MV <= BUCK3_BASE_MV + 12'(buck3_alt_voltage_q[6:0] * 8'd20);
            BUCK4_ALT_MV <= BUCK4_BASE_MV + 12'(buck4_alt_voltage_q[6:0] * 8'd10);
            LINEAR_ALT_LOW_POWER <= lin_lp & LINEAR_ALT_ACTIVE;
            LINEAR_ALT_MV <= lin_mv_d;
            BACKUP_CHARGE_UA <= ua_d;
            BACKUP_CHARGE_TERM_MV <= term_d;
            TARGET_ADDRESS <= {target_address_high_q, 3'h0};
            BUS_HIGH_SPEED_LOCK <= pin_and_bus_config_q[HSM_BIT];
            BUS_FAST_PLUS_SELECT <= pin_and_bus_config_q[FMP_BIT];
            INTERRUPT_REQUEST_PIN_OUT <= odrain ? 1'b0 : irq_level;
            INTERRUPT_REQUEST_PIN_OE <= odrain ? ~irq_level : 1'b1;
            SYSTEM_RESET_PIN_OUT <= odrain ? 1'b0 : rst_level;
            SYSTEM_RESET_PIN_OE <= odrain ? ~rst_level : 1'b1;
            SUPPLY_FAULT_HYST_MV <= HYST_BASE_MV
                + 12'({9'h000, supply_fault_config_q[6:4]} * STEP_50_MV);
            SUPPLY_FAULT_THRESH_MV <= FAULT_BASE_MV
                + 12'({8'h00, supply_fault_config_q[3:0]} * STEP_50_MV);
            BUCK_CLOCK_INVERT <= {buck_clock_config_q[B4_INV_BIT], buck_clock_config_q[B3_INV_BIT],
                                  buck_clock_config_q[B1_INV_BIT]};
            BUCK_RAIL_DISCHARGE <= buck_clock_config_q[DISCHG_BIT];
        end
    end
endmodule
`default_nettype wire

// ### verification/psr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module psr_host_model (
    // Core clock paces the bus.
    input wire logic clk,
    // Open-drain bus; the pull-up gives the high level.
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic hc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Data settles well before the rise, since the target filters both lines by three flops.
    task automatic bit_io(input logic b, output logic r);
        hc(2);
        sda_low = ~b;
        hc(10);
        scl = 1'b1;
        hc(6);
        r = sda;
        hc(6);
        scl = 1'b0;
    endtask
    // SDA must fall, or for a stop rise, while SCL is high; start also serves a repeated start.
    task automatic start();
        hc(2);
        sda_low = 1'b0;
        hc(10);
        scl = 1'b1;
        hc(10);
        sda_low = 1'b1;
        hc(10);
        scl = 1'b0;
    endtask
    task automatic stop();
        hc(2);
        sda_low = 1'b1;
        hc(10);
        scl = 1'b1;
        hc(10);
        sda_low = 1'b0;
        hc(10);
    endtask
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(last, a);
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d, output logic n);
        logic [7:0] q;
        logic [2:0] a;
        start();
        xfer({dev, 1'b0}, 1'b1, q, a[0]);
        xfer(p, 1'b1, q, a[1]);
        xfer(d, 1'b1, q, a[2]);
        stop();
        n = |a;
    endtask
    task automatic rd(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] q, output logic n);
        logic [7:0] x;
        logic [3:0] a;
        start();
        xfer({dev, 1'b0}, 1'b1, x, a[0]);
        xfer(p, 1'b1, x, a[1]);
        start();
        xfer({dev, 1'b1}, 1'b1, x, a[2]);
        xfer(8'hFF, 1'b1, q, a[3]);
        stop();
        n = |a[2:0];
    endtask
endmodule
`default_nettype wire

// ### verification/psr_setting_bank_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module psr_setting_bank_monitor (
    // Watched ports.
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic [5:0] BUCK_OPERATING_SELECT,
    input wire logic [2:0] BUCK_ALT_ACTIVE,
    input wire logic [2:0] BUCK_PRIMARY_SLEEP,
    input wire logic [2:0] BUCK_PFM,
    input wire logic [2:0] BUCK_AUTO,
    input wire logic [11:0] BUCK1_ALT_MV,
    input wire logic [3:0] LINEAR_ALT_ACTIVE,
    input wire logic [3:0] LINEAR_ALT_LOW_POWER,
    input wire logic [47:0] LINEAR_ALT_MV,
    input wire logic [6:0] TARGET_ADDRESS,
    input wire logic UNMARKED_PART,
    input wire logic APP_CONFIG_FUSE_LOCK,
    input wire logic RESET_REQUEST,
    input wire logic SYSTEM_RESET_PIN_OUT,
    input wire logic SYSTEM_RESET_PIN_OE,
    input wire logic INTERRUPT_REQUEST_PIN_OUT,
    input wire logic INTERRUPT_REQUEST_PIN_OE,
    input wire logic [11:0] SUPPLY_FAULT_HYST_MV
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    a_addr_low_zero: assert property (TARGET_ADDRESS[2:0] == 3'h0)
        else $error("target address low bits not zero");
    a_addr_locked: assert property ($changed(TARGET_ADDRESS)
        |-> UNMARKED_PART && !APP_CONFIG_FUSE_LOCK) else $error("target address changed while locked");
    a_pfm_primary: assert property (BUCK_OPERATING_SELECT[1:0] == 2'h0 && !BUCK_ALT_ACTIVE[0]
        |=> BUCK_PFM[0] == $past(BUCK_PRIMARY_SLEEP[0])) else $error("alt sleep bit acted while idle");
    a_select_forced: assert property (BUCK_OPERATING_SELECT[1:0] != 2'h0
        |=> BUCK_PFM[0] == ($past(BUCK_OPERATING_SELECT[1:0]) == 2'h1)
        && BUCK_AUTO[0] == ($past(BUCK_OPERATING_SELECT[1:0]) == 2'h3)) else $error("buck select decode");
    a_low_power_gate: assert property (!LINEAR_ALT_ACTIVE[0] |=> !LINEAR_ALT_LOW_POWER[0])
        else $error("low power without alt active");
    a_linear_clamp: assert property (LINEAR_ALT_MV[11:0] >= 12'h384
        && LINEAR_ALT_MV[11:0] <= 12'hE10
        && (LINEAR_ALT_MV[11:0] - 12'h384) % 12'h032 == 12'h000) else $error("linear level out of range");
    a_buck1_grid: assert property (BUCK1_ALT_MV >= 12'h12C
        && BUCK1_ALT_MV <= 12'h622
        && (BUCK1_ALT_MV - 12'h12C) % 12'h00A == 12'h000) else $error("buck1 level off grid");
    a_hyst_grid: assert property (SUPPLY_FAULT_HYST_MV >= 12'h064
        && SUPPLY_FAULT_HYST_MV <= 12'h1C2
        && (SUPPLY_FAULT_HYST_MV - 12'h064) % 12'h032 == 12'h000) else $error("hysteresis off grid");
    a_reset_pin_low: assert property (RESET_REQUEST |=> SYSTEM_RESET_PIN_OE && !SYSTEM_RESET_PIN_OUT)
        else $error("reset pin not pulled low");
    a_irq_high_drive: assert property (INTERRUPT_REQUEST_PIN_OUT |-> INTERRUPT_REQUEST_PIN_OE)
        else $error("interrupt pin high while undriven");
    c_auto: cover property (BUCK_AUTO[0]);
    c_irq_released: cover property (!INTERRUPT_REQUEST_PIN_OE);
    c_addr_moved: cover property (TARGET_ADDRESS != 7'h30);
endmodule
bind psr_setting_bank psr_setting_bank_monitor u_mon (.REF_CLK, .SYS_RST, .BUCK_OPERATING_SELECT,
    .BUCK_ALT_ACTIVE, .BUCK_PRIMARY_SLEEP, .BUCK_PFM, .BUCK_AUTO, .BUCK1_ALT_MV, .LINEAR_ALT_ACTIVE,
    .LINEAR_ALT_LOW_POWER, .LINEAR_ALT_MV, .TARGET_ADDRESS, .UNMARKED_PART, .APP_CONFIG_FUSE_LOCK,
    .RESET_REQUEST, .SYSTEM_RESET_PIN_OUT, .SYSTEM_RESET_PIN_OE, .INTERRUPT_REQUEST_PIN_OUT,
    .INTERRUPT_REQUEST_PIN_OE, .SUPPLY_FAULT_HYST_MV);
`default_nettype wire

// ### verification/psr_setting_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module psr_setting_bank_tb;
    import psr_pkg::*;
    logic clk, rst, unm, lock, irq_req, rst_req, sda_oe, sda_out, scl, sda_low, n;
    logic hs, fmp, irq_o, irq_oe, rp_o, rp_oe, dis;
    logic [5:0] sel;
    logic [2:0] b_alt, b_pri, b_pfm, b_auto, b_inv;
    logic [3:0] l_act, l_lp;
    logic [11:0] b1_mv, b3_mv, b4_mv, hyst, thr, term;
    logic [12:0] ua;
    logic [47:0] lin_mv;
    logic [6:0] taddr, dev0;
    logic [7:0] lv[4] = '{8'h01, 8'h38, 8'h7F, 8'hC5};
    logic [7:0] bc[4] = '{8'hFF, 8'h9D, 8'hA1, 8'h00};
    logic [24:0] bx[4] = '{25'h1770C1C, 25'h0384B54, 25'h03E844C, 25'h0000000};
    int miscompares = 0;
    int tests_run = 0;
    wire logic sda = !(sda_oe && !sda_out) && !sda_low;
    psr_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    psr_setting_bank dut (.REF_CLK(clk), .SYS_RST(rst), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .UNMARKED_PART(unm), .APP_CONFIG_FUSE_LOCK(lock),
        .BUCK_OPERATING_SELECT(sel), .BUCK_ALT_ACTIVE(b_alt), .BUCK_PRIMARY_SLEEP(b_pri),
        .BUCK_PFM(b_pfm), .BUCK_AUTO(b_auto), .BUCK1_ALT_MV(b1_mv), .BUCK3_ALT_MV(b3_mv),
        .BUCK4_ALT_MV(b4_mv), .LINEAR_ALT_ACTIVE(l_act), .LINEAR_ALT_LOW_POWER(l_lp),
        .LINEAR_ALT_MV(lin_mv), .BACKUP_CHARGE_UA(ua), .BACKUP_CHARGE_TERM_MV(term),
        .TARGET_ADDRESS(taddr), .BUS_HIGH_SPEED_LOCK(hs), .BUS_FAST_PLUS_SELECT(fmp),
        .IRQ_REQUEST(irq_req), .INTERRUPT_REQUEST_PIN_OUT(irq_o), .INTERRUPT_REQUEST_PIN_OE(irq_oe),
        .RESET_REQUEST(rst_req), .SYSTEM_RESET_PIN_OUT(rp_o), .SYSTEM_RESET_PIN_OE(rp_oe),
        .SUPPLY_FAULT_HYST_MV(hyst), .SUPPLY_FAULT_THRESH_MV(thr), .BUCK_CLOCK_INVERT(b_inv),
        .BUCK_RAIL_DISCHARGE(dis));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Page 0x1xx sits on the odd device address.
    task automatic wreg(input logic [8:0] a, input logic [7:0] d);
        host.wr(dev0 | 7'(a[8]), a[7:0], d, n);
        chk(n, 48'h0);
    endtask
    task automatic rreg(input logic [8:0] a, input logic [7:0] e);
        logic [7:0] q;
        host.rd(dev0 | 7'(a[8]), a[7:0], q, n);
        chk({n, q}, 48'(e));
    endtask
    task automatic gap();
        repeat (3) @(negedge clk);
    endtask
    initial
    begin
        repeat (95000) @(posedge clk);
        miscompares++;
        finish_test();
    end
    initial
    begin
        {rst, lock, unm, irq_req, rst_req} = 5'h10 | 5'h08;
        {sel, b_alt, b_pri, l_act} = 16'h0000;
        dev0 = 7'h30;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk({taddr, b1_mv}, {7'h30, 12'h12C});
        wreg(ADDR_BUCK1_ALT, 8'hFF);
        wreg(ADDR_BUCK4_ALT, 8'h7F);
        wreg(ADDR_BUCK3_ALT, 8'h01);
        chk({b1_mv, b4_mv, b3_mv}, 36'h622708334);
        rreg(ADDR_BUCK1_ALT, 8'hFF);
        b_alt = 3'h1;
        for (int s = 0; s < 4; s++)
        begin
            sel = 6'(s);
            gap();
            chk({b_pfm[0], b_auto[0]}, {s < 2, s == 3});
        end
        sel = 6'h00;
        wreg(ADDR_BUCK1_ALT, 8'h7F);
        chk(b_pfm[0], 48'h0);
        {b_alt, b_pri} = 6'h07;
        gap();
        chk(b_pfm[0], 48'h1);
        for (int i = 0; i < 4; i++)
            wreg(ADDR_LIN1_ALT + 9'(i), lv[i]);
        l_act = 4'hC;
        gap();
        chk({l_lp, lin_mv}, {4'h8, 48'h41AE10E10384});
        for (int i = 0; i < 4; i++)
            rreg(ADDR_LIN1_ALT + 9'(i), lv[i]);
        // Charger codes at the ends of both ladders plus the first milliamp step.
        for (int i = 0; i < 4; i++)
        begin
            wreg(ADDR_BACKUP_CHG, bc[i]);
            chk({ua, term}, 48'(bx[i]));
        end
        {irq_req, rst_req} = 2'h3;
        wreg(ADDR_PIN_BUS_CFG, 8'hFF);
        rreg(ADDR_PIN_BUS_CFG, 8'h7F);
        chk({hs, fmp, irq_o, irq_oe, rp_o, rp_oe}, 48'h31);
        wreg(ADDR_PIN_BUS_CFG, 8'h08);
        chk({hs, fmp, irq_o, irq_oe, rp_o, rp_oe}, 48'h0D);
        wreg(ADDR_FAULT_CFG, 8'h7F);
        chk({hyst, thr}, 24'h1C2CB2);
        wreg(ADDR_CLOCK_CFG, 8'h48);
        chk({b_inv, dis}, 4'h6);
        wreg(ADDR_CLOCK_CFG, 8'hB4);
        chk({b_inv, dis}, 4'h9);
        rreg(ADDR_CLOCK_CFG, 8'hB4);
        wreg(ADDR_TARGET_ADDR, 8'h50);
        rreg(ADDR_TARGET_ADDR, 8'h60);
        {unm, lock} = 2'h2;
        wreg(ADDR_TARGET_ADDR, 8'h5A);
        chk(taddr, 48'h28);
        dev0 = 7'h28;
        rreg(ADDR_TARGET_ADDR, 8'h50);
        host.wr(7'h30, 8'hB5, 8'h00, n);
        chk({n, b1_mv}, {1'b1, 12'h622});
        finish_test();
    end
endmodule
`default_nettype wire
